/* File: hdl/cawd_params.svh */
// Purpose: constants for the counter array pwm and watchdog block
// Assumes: byte wide register port, one clock domain
// Notes: offsets are byte addresses on the plain register port
`ifndef CAWD_PARAMS_SVH
`define CAWD_PARAMS_SVH

`define CAWD_NMOD       6
`define CAWD_WD_MOD     5
`define CAWD_A_CTRL     8'h00
`define CAWD_A_MODE     8'h01
`define CAWD_A_PWMCFG   8'h02
`define CAWD_A_CNTL     8'h03
`define CAWD_A_CNTH     8'h04
`define CAWD_A_MODM     8'h10
`define CAWD_A_CPL      8'h20
`define CAWD_A_CPH      8'h30

`define CAWD_MD_PWM16   7
`define CAWD_MD_ECOM    6
`define CAWD_MD_MAT     3
`define CAWD_MD_PWM     1

`define CAWD_CTRL_FORCE 5
`define CAWD_WATCHDOG_ENABLE_BIT_RST   1'b1
`define CAWD_DIV_SYS12  4'd12
`define CAWD_DIV_SYS4   4'd4
`define CAWD_CPS_DIV12  3'd0
`define CAWD_CPS_DIV4   3'd1
`define CAWD_CPS_EXT    3'd2

`endif

/* File: hdl/cawd_pkg.sv */
// Purpose: types for the counter array pwm and watchdog block
// Assumes: six capture/compare modules
// Notes: all block state is one packed struct
`include "cawd_params.svh"
package cawd_pkg;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} cawd_bus_t;

	typedef struct packed {
		logic [7:0]  mode;
		logic [15:0] cp;
		logic [15:0] arr;
		logic        pin;
	} cawd_mod_t;

	typedef struct packed {
		logic                      cf;
		logic                      cr;
		logic [`CAWD_NMOD-1:0]     ccf;
		logic                      idle_suspend_bit;
		logic                      watchdog_enable_bit;
		logic                      watchdog_lock_bit;
		logic [2:0]                cps;
		logic                      ecf;
		logic                      autoreload_select;
		logic                      pwm_overflow_flag;
		logic [1:0]                cycle_length_select;
		logic [15:0]               cnt;
		logic [3:0]                div;
		cawd_mod_t [`CAWD_NMOD-1:0] m;
		logic                      wd_req;
		logic [7:0]                rdata;
	} cawd_state_t;

endpackage : cawd_pkg

/* File: hdl/cawd_top.sv */
// Purpose: pwm modes of the counter array and the module five watchdog
// Assumes: inputs synchronous to clk_sys, single cycle register strobes
// Notes: capture, timer, toggle and frequency modes are not built here
`timescale 1ns/1ps
`include "cawd_params.svh"
module cawd_top
	import cawd_pkg::*;
(
	// clock, reset, enable
	input  wire logic                  clk_sys,
	input  wire logic                  nrst,
	input  wire logic                  ce,
	// register port
	input  wire cawd_bus_t             bus,
	output logic [7:0]                 rd_data,
	// counter clock sources and idle
	input  wire logic                  ext_tick,
	input  wire logic                  cpu_idle,
	// module pins
	output logic [`CAWD_NMOD-1:0]      module_output_pin,
	// system reset logic
	output logic                       wd_reset_req,
	input  wire logic                  wd_reset_ack
);

////////////////////////////////////////////////////////////////////////////////

	cawd_state_t q;
	cawd_state_t d;

	logic        wd_en;
	logic        div_wrap;
	logic        src;
	logic        tick;
	logic [15:0] cnt_n;
	logic [15:0] mask;
	logic        lo_ovf;
	logic        n_ovf;
	logic        full_ovf;
	logic        wd_hit;
	logic        wd_force;
	logic [3:0]  hm_mode;
	logic [3:0]  hm_lo;
	logic [3:0]  hm_hi;

	// bit 3 is the hit, bits 2:0 the module index
	function automatic logic [3:0] mod_hit(input logic [7:0] a,
	                                       input logic [7:0] base);
		logic ok;
		ok = (a[7:4] == base[7:4]) && (a[3:0] < 4'(`CAWD_NMOD));
		return {ok, a[2:0]};
	endfunction : mod_hit

	// low n bits of the counter for the shared cycle length
	function automatic logic [15:0] pwm_mask(input logic [1:0] sel);
		logic [15:0] r;
		r = 16'h00ff;
		unique case (sel)
			2'b00: r = 16'h00ff;
			2'b01: r = 16'h01ff;
			2'b10: r = 16'h03ff;
			2'b11: r = 16'h07ff;
		endcase
		return r;
	endfunction : pwm_mask

////////////////////////////////////////////////////////////////////////////////
// counter clock and overflow events

	assign wd_en    = q.watchdog_enable_bit | q.watchdog_lock_bit;
	assign div_wrap = (q.cps == `CAWD_CPS_DIV12 &&
	                   q.div == `CAWD_DIV_SYS12 - 4'd1) ||
	                  (q.cps == `CAWD_CPS_DIV4 &&
	                   q.div == `CAWD_DIV_SYS4 - 4'd1) ||
	                  (q.div == 4'hf);
	assign src      = (q.cps == `CAWD_CPS_DIV12 || q.cps == `CAWD_CPS_DIV4) ?
	                  div_wrap :
	                  (q.cps == `CAWD_CPS_EXT) ? ext_tick : 1'b1;
	// watchdog keeps the counter running whatever the run bit says
	assign tick     = src & (q.cr | wd_en) & ~(q.idle_suspend_bit & cpu_idle);
	assign cnt_n    = q.cnt + 16'h0001;
	assign mask     = pwm_mask(q.cycle_length_select);
	assign lo_ovf   = tick & (q.cnt[7:0] == 8'hff);
	assign n_ovf    = tick & ((q.cnt & mask) == mask);
	assign full_ovf = tick & (q.cnt == 16'hffff);
	// timeout is offset pages plus what is left of the current page
	assign wd_hit   = lo_ovf & wd_en &
	                  (q.m[`CAWD_WD_MOD].cp[15:8] == q.cnt[15:8]);
	assign wd_force = wd_en & bus.wr & (bus.addr == `CAWD_A_CTRL) &
	                  bus.wdata[`CAWD_CTRL_FORCE];
	assign hm_mode  = mod_hit(bus.addr, `CAWD_A_MODM);
	assign hm_lo    = mod_hit(bus.addr, `CAWD_A_CPL);
	assign hm_hi    = mod_hit(bus.addr, `CAWD_A_CPH);

////////////////////////////////////////////////////////////////////////////////
// next state

	always_comb begin
		logic [15:0] cpv;
		logic        match;
		logic        ovf;
		logic        act;
		logic        wdm;
		cpv   = 16'h0000;
		match = 1'b0;
		ovf   = 1'b0;
		act   = 1'b0;
		wdm   = 1'b0;
		d     = q;
		d.div = div_wrap ? 4'h0 : q.div + 4'h1;
		if (tick) begin
			d.cnt = cnt_n;
		end

		if (bus.wr) begin
			unique case (bus.addr)
				`CAWD_A_CTRL: begin
					d.cf  = bus.wdata[7];
					d.cr  = bus.wdata[6];
					d.ccf = bus.wdata[`CAWD_NMOD-1:0];
				end
				`CAWD_A_MODE: begin
					if (!wd_en) begin
						d.idle_suspend_bit = bus.wdata[7];
						d.cps  = bus.wdata[3:1];
					end
					d.watchdog_enable_bit  = bus.wdata[6];
					d.watchdog_lock_bit = q.watchdog_lock_bit | bus.wdata[5];
					d.ecf   = bus.wdata[0];
				end
				`CAWD_A_PWMCFG: begin
					d.autoreload_select = bus.wdata[7];
					d.pwm_overflow_flag  = bus.wdata[5];
					d.cycle_length_select = bus.wdata[1:0];
				end
				`CAWD_A_CNTL: begin
					if (!wd_en) begin
						d.cnt[7:0] = bus.wdata;
					end
				end
				`CAWD_A_CNTH: begin
					if (!wd_en) begin
						d.cnt[15:8] = bus.wdata;
					end
				end
				default: begin
				end
			endcase
		end

		for (int i = 0; i < `CAWD_NMOD; i++) begin
			wdm = wd_en && (i == `CAWD_WD_MOD);
			if (bus.wr && hm_mode[3] && hm_mode[2:0] == 3'(i) && !wdm) begin
				d.m[i].mode = bus.wdata;
			end
			if (bus.wr && hm_lo[3] && hm_lo[2:0] == 3'(i)) begin
				if (wdm) begin
					d.m[i].cp[7:0] = bus.wdata;
				end else begin
					if (q.autoreload_select) begin
						d.m[i].arr[7:0] = bus.wdata;
					end else begin
						d.m[i].cp[7:0] = bus.wdata;
					end
					d.m[i].mode[`CAWD_MD_ECOM] = 1'b0;
				end
			end
			if (bus.wr && hm_hi[3] && hm_hi[2:0] == 3'(i)) begin
				if (wdm) begin
					// any value written restarts the timeout
					d.m[i].cp[15:8] = 8'(q.cnt[15:8] + q.m[i].cp[7:0]);
				end else begin
					if (q.autoreload_select) begin
						d.m[i].arr[15:8] = bus.wdata;
					end else begin
						d.m[i].cp[15:8] = bus.wdata;
					end
					d.m[i].mode[`CAWD_MD_ECOM] = 1'b1;
				end
			end

			cpv   = d.m[i].cp;
			match = 1'b0;
			ovf   = 1'b0;
			act   = q.m[i].mode[`CAWD_MD_PWM] &&
			        q.m[i].mode[`CAWD_MD_ECOM] && !wdm;
			if (act && q.m[i].mode[`CAWD_MD_PWM16]) begin
				match = tick && (cnt_n == cpv);
				ovf   = full_ovf;
			end else if (act && q.cycle_length_select == 2'b00) begin
				if (lo_ovf) begin
					cpv[7:0] = cpv[15:8];
				end
				match = tick && (cnt_n[7:0] == cpv[7:0]);
				ovf   = lo_ovf;
			end else if (act) begin
				if (n_ovf) begin
					cpv = q.m[i].arr;
				end
				match = tick && ((cnt_n & mask) == (cpv & mask));
				ovf   = n_ovf;
			end
			d.m[i].cp = cpv;

			// match is seen on the new count so a zero value holds high
			if ((q.m[i].mode[`CAWD_MD_PWM] &&
			     !q.m[i].mode[`CAWD_MD_ECOM]) || wdm) begin
				d.m[i].pin = 1'b0;
			end else if (match) begin
				d.m[i].pin = 1'b1;
			end else if (ovf) begin
				d.m[i].pin = 1'b0;
			end
			if (match && q.m[i].mode[`CAWD_MD_MAT]) begin
				d.ccf[i] = 1'b1;
			end
		end

		// hardware sets win over a software clear in the same cycle
		if (full_ovf) begin
			d.cf = 1'b1;
		end
		if (n_ovf) begin
			d.pwm_overflow_flag = 1'b1;
		end
		if (wd_reset_ack) begin
			d.wd_req = 1'b0;
		end
		if (wd_hit || wd_force) begin
			d.wd_req = 1'b1;
		end

		d.rdata = 8'h00;
		if (bus.rd) begin
			unique case (bus.addr)
				`CAWD_A_CTRL: begin
					d.rdata = {q.cf, q.cr, q.ccf};
				end
				`CAWD_A_MODE: begin
					d.rdata = {q.idle_suspend_bit, q.watchdog_enable_bit, q.watchdog_lock_bit, 1'b0, q.cps, q.ecf};
				end
				`CAWD_A_PWMCFG: begin
					d.rdata = {q.autoreload_select, 1'b0, q.pwm_overflow_flag, 3'b000, q.cycle_length_select};
				end
				`CAWD_A_CNTL: begin
					d.rdata = q.cnt[7:0];
				end
				`CAWD_A_CNTH: begin
					d.rdata = q.cnt[15:8];
				end
				default: begin
					if (hm_mode[3]) begin
						d.rdata = q.m[hm_mode[2:0]].mode;
					end else if (hm_lo[3]) begin
						d.rdata = q.autoreload_select ? q.m[hm_lo[2:0]].arr[7:0] :
						          q.m[hm_lo[2:0]].cp[7:0];
					end else if (hm_hi[3]) begin
						d.rdata = q.autoreload_select ? q.m[hm_hi[2:0]].arr[15:8] :
						          q.m[hm_hi[2:0]].cp[15:8];
					end
				end
			endcase
		end
	end

////////////////////////////////////////////////////////////////////////////////
// state register

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			q      <= '0;
			q.watchdog_enable_bit <= `CAWD_WATCHDOG_ENABLE_BIT_RST;
		end else if (ce) begin
			q <= d;
		end
	end

	assign rd_data      = q.rdata;
	assign wd_reset_req = q.wd_req;

	for (genvar g = 0; g < `CAWD_NMOD; g++) begin : g_pin
		assign module_output_pin[g] = q.m[g].pin;
	end

////////////////////////////////////////////////////////////////////////////////
// checks

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);

	sequence s_update_wr;
		ce && wd_en && bus.wr && bus.addr == (`CAWD_A_CPH + 8'h05);
	endsequence

	sequence s_page_end;
		ce && tick && wd_en && q.cnt[7:0] == 8'hff &&
		q.m[`CAWD_WD_MOD].cp[15:8] == q.cnt[15:8];
	endsequence

	a_off_pin_low: assert property (
		(ce && q.m[0].mode[`CAWD_MD_PWM] && !q.m[0].mode[`CAWD_MD_ECOM])
		|=> !q.m[0].pin)
		else $error("pin not low with compare disabled");

	a_lo_wr_ecom: assert property (
		(ce && bus.wr && bus.addr == `CAWD_A_CPL) |=>
		!q.m[0].mode[`CAWD_MD_ECOM])
		else $error("low byte write kept compare enable");

	a_hi_wr_ecom: assert property (
		(ce && bus.wr && bus.addr == `CAWD_A_CPH) |=>
		q.m[0].mode[`CAWD_MD_ECOM])
		else $error("high byte write did not set compare enable");

	a_autoreload_select_map: assert property (
		(ce && bus.wr && bus.addr == `CAWD_A_CPL && q.autoreload_select) |=>
		q.m[0].arr[7:0] == $past(bus.wdata) &&
		q.m[0].cp[7:0] == $past(q.m[0].cp[7:0], 1) | $past(n_ovf))
		else $error("select bit did not route write to reload");

	a_lock_sticky: assert property (
		q.watchdog_lock_bit |=> q.watchdog_lock_bit && wd_en)
		else $error("lock bit dropped");

	a_cnt_guard: assert property (
		(ce && wd_en && tick) |=> q.cnt == $past(cnt_n))
		else $error("counter not running freely under watchdog");

	a_update_load: assert property (
		s_update_wr |=> q.m[`CAWD_WD_MOD].cp[15:8] ==
		8'($past(q.cnt[15:8]) + $past(q.m[`CAWD_WD_MOD].cp[7:0])))
		else $error("update write loaded wrong value");

	a_wd_timeout: assert property (
		s_page_end |=> q.wd_req && wd_reset_req)
		else $error("watchdog missed its timeout");

	a_force_rst: assert property (
		(ce && wd_en && bus.wr && bus.addr == `CAWD_A_CTRL &&
		 bus.wdata[`CAWD_CTRL_FORCE]) |=> wd_reset_req)
		else $error("forced watchdog reset missing");

	a_req_hold: assert property (
		(q.wd_req && !wd_reset_ack) |=> q.wd_req)
		else $error("reset request dropped before ack");

	a_cf_wrap: assert property (
		(ce && tick && q.cnt == 16'hffff) |=> q.cf && q.cnt == 16'h0000)
		else $error("wrap did not set overflow flag");

	a_pwm_reload: assert property (
		(ce && n_ovf && q.cycle_length_select != 2'b00 && !bus.wr &&
		 q.m[0].mode[`CAWD_MD_PWM] && q.m[0].mode[`CAWD_MD_ECOM] &&
		 !q.m[0].mode[`CAWD_MD_PWM16])
		|=> q.pwm_overflow_flag && q.m[0].cp == $past(q.m[0].arr))
		else $error("overflow did not reload compare value");

	a_rd_once: assert property (
		(ce && !bus.rd) |=> rd_data == 8'h00)
		else $error("read data outside read cycle");

endmodule : cawd_top

/* File: sim/cawd_rst_model.sv */
// Purpose: system reset logic that takes watchdog reset requests
// Assumes: request is a level held until acknowledged
// Notes: ack delay is programmable so the model acts prompt or slow
`timescale 1ns/1ps
module cawd_rst_model (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       nrst,
	// pacing
	input  wire logic [3:0] ack_dly,
	// request handshake
	input  wire logic       wd_reset_req,
	output logic            wd_reset_ack
);
	logic [3:0] wait_q;

	// ack only after the request has stood for ack_dly edges
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			wait_q       <= 4'h0;
			wd_reset_ack <= 1'b0;
		end else if (wd_reset_req !== 1'b1) begin
			wait_q       <= 4'h0;
			wd_reset_ack <= 1'b0;
		end else if (wait_q >= ack_dly) begin
			wd_reset_ack <= 1'b1;
		end else begin
			wait_q <= wait_q + 4'h1;
		end
	end
endmodule : cawd_rst_model

/* File: sim/cawd_tb_top.sv */
// Purpose: self-checking bench for the pwm modes and the watchdog
// Assumes: seed 70, counter clock every sys clock for pwm runs
// Notes: watchdog timing checked against the sys/12 default clock
`timescale 1ns/1ps
`include "cawd_params.svh"
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin \
	mismatches++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module counter_array_pwm_watchdog_tb_top;
	import cawd_pkg::*;

	logic                  clk_sys;
	logic                  nrst;
	logic                  wd_reset_req;
	logic                  wd_reset_ack;
	logic                  ce;
	logic                  cpu_idle;
	logic                  ext_tick;
	cawd_bus_t             bus;
	logic [7:0]            rd_data;
	logic [7:0]            rv;
	logic [`CAWD_NMOD-1:0] module_output_pin;
	logic [3:0]            ack_dly;
	logic [15:0]           v;
	int                    mismatches;
	int                    checks_done;
	int                    seed;
	int                    n;
	int                    cnt;
	int                    el;
	int                    c0;
	int                    cyc = 0;

	cawd_top dut (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .bus(bus),
		.rd_data(rd_data), .ext_tick(ext_tick), .cpu_idle(cpu_idle),
		.module_output_pin(module_output_pin),
		.wd_reset_req(wd_reset_req), .wd_reset_ack(wd_reset_ack));
	cawd_rst_model sysrst (.clk_sys(clk_sys), .nrst(nrst),
		.ack_dly(ack_dly), .wd_reset_req(wd_reset_req),
		.wd_reset_ack(wd_reset_ack));

	////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys) bus <= {a, d, 2'b10};
		@(posedge clk_sys) bus.wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys) bus <= {a, 8'h00, 2'b01};
		@(posedge clk_sys) bus.rd <= 1'b0;
		#1 rv = rd_data;
	endtask : rd

	task automatic wait_req(input int lim);
		cnt = 0;
		while (wd_reset_req !== 1'b1 && cnt < lim) begin
			@(posedge clk_sys);
			cnt++;
		end
		el = cyc - c0;
	endtask : wait_req

	task automatic hi_cnt(input int idx, input int len);
		cnt = 0;
		repeat (len) begin
			@(posedge clk_sys);
			#1 cnt += (module_output_pin[idx] === 1'b1);
		end
	endtask : hi_cnt

	task automatic do_reset();
		@(posedge clk_sys) nrst <= 1'b0;
		repeat (10) @(posedge clk_sys);
		nrst <= 1'b1;
		c0 = cyc;
	endtask : do_reset

	function automatic int duty(input int nb, input int val);
		return (1 << nb) - val;
	endfunction : duty

	function automatic int wd_clks(input int off, input int low);
		return (256 * off + 256 - low) * 12;
	endfunction : wd_clks

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : wrap_up

	////////////////////////////////////////////////////////////////////
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) cyc <= cyc + 1;

	initial begin
		repeat (60000) @(posedge clk_sys);
		mismatches++;
		wrap_up();
	end

	initial begin
		nrst = 1'b0;
		bus = '0;
		ce = 1'b1;
		cpu_idle = 1'b0;
		ext_tick = 1'b0;
		ack_dly = 4'h1;
		seed = 70;
		mismatches = 0;
		checks_done = 0;
		// defaults, frozen writes, default timeout
		do_reset();
		rd(`CAWD_A_MODE);
		`CHK("mode", 8'h40, rv)
		rd(`CAWD_A_CTRL);
		`CHK("ctrl", 8'h00, rv)
		wr(`CAWD_A_CNTL, 8'h80);
		wr(`CAWD_A_MODE, 8'h4e);
		rd(`CAWD_A_MODE);
		`CHK("mode", 8'h40, rv)
		wait_req(4000);
		`CHK("wd tmo", 1'b1, el >= wd_clks(0, 0) - 24 && el <= 3096)
		repeat (8) @(posedge clk_sys);
		#1 `CHK("req", 1'b0, wd_reset_req)
		`CHK("wd pin", 1'b0, module_output_pin[5])
		// update with offset, reconfigured in the safe order
		do_reset();
		wr(`CAWD_A_MODE, 8'h00);
		wr(`CAWD_A_CPL + 8'h05, 8'h02);
		wr(`CAWD_A_MODE, 8'h40);
		wr(`CAWD_A_CPH + 8'h05, 8'h5a);
		rd(`CAWD_A_CPH + 8'h05);
		`CHK("update", 8'h02, rv)
		wait_req(12000);
		`CHK("wd tmo2", 1'b1, el >= wd_clks(2, 1) - 24 && el <= 9240)
		// forced reset, slow ack, lock
		do_reset();
		ack_dly = 4'h6;
		wr(`CAWD_A_CTRL, 8'h20);
		repeat (4) @(posedge clk_sys);
		#1 `CHK("force", 1'b1, wd_reset_req)
		repeat (8) @(posedge clk_sys);
		#1 `CHK("req", 1'b0, wd_reset_req)
		wr(`CAWD_A_MODE, 8'h20);
		wr(`CAWD_A_MODE, 8'h00);
		rd(`CAWD_A_MODE);
		`CHK("lock", 8'h20, rv & 8'h20)
		// watchdog off, counter on every clock, 8-bit pwm
		ack_dly = 4'h1;
		do_reset();
		wr(`CAWD_A_MODE, 8'h00);
		rd(`CAWD_A_MODE);
		`CHK("wd off", 8'h00, rv)
		wr(`CAWD_A_MODE, 8'h06);
		wr(`CAWD_A_CTRL, 8'h40);
		wr(`CAWD_A_MODM, 8'h02);
		for (n = 0; n < 3; n++) begin
			v = (n == 0) ? 16'h0000 : 16'h00ff;
			if (n == 2)
				v = 16'($random(seed)) & 16'h00ff;
			wr(`CAWD_A_CPL, v[7:0]);
			rd(`CAWD_A_MODM);
			`CHK("ecom clr", 8'h02, rv)
			hi_cnt(0, 512);
			`CHK("duty0", 0, cnt)
			wr(`CAWD_A_CPH, v[7:0]);
			rd(`CAWD_A_MODM);
			`CHK("ecom set", 8'h42, rv)
			repeat (512) @(posedge clk_sys);
			hi_cnt(0, 256);
			`CHK("duty8", duty(8, v), cnt)
		end
		// 9, 10, 11-bit pwm through the reload registers
		for (n = 9; n <= 11; n++) begin
			v = 16'($random(seed)) & 16'((1 << n) - 1);
			wr(`CAWD_A_PWMCFG, 8'h80 | 8'(n - 8));
			wr(`CAWD_A_CPL, v[7:0]);
			wr(`CAWD_A_CPH, v[15:8]);
			wr(`CAWD_A_MODM, 8'h4a);
			rd(`CAWD_A_CPL);
			`CHK("reload", v[7:0], rv)
			repeat (1 << (n + 1)) @(posedge clk_sys);
			hi_cnt(0, 1 << n);
			`CHK("dutyn", duty(n, v), cnt)
			rd(`CAWD_A_PWMCFG);
			`CHK("pwm_overflow_flag", 8'h20, rv & 8'h20)
			rd(`CAWD_A_CTRL);
			`CHK("match flag", 8'h01, rv & 8'h01)
		end
		wr(`CAWD_A_MODM, 8'h00);
		wr(`CAWD_A_PWMCFG, 8'h00);
		rd(`CAWD_A_CPL);
		`CHK("cp", v[7:0], rv)
		// 16-bit pwm near the counter wrap
		wr(`CAWD_A_CTRL, 8'h40);
		wr(`CAWD_A_CNTL, 8'h00);
		wr(`CAWD_A_CNTH, 8'hff);
		wr(`CAWD_A_MODM + 8'h01, 8'h8a);
		wr(`CAWD_A_CPL + 8'h01, 8'h80);
		wr(`CAWD_A_CPH + 8'h01, 8'hff);
		hi_cnt(1, 300);
		`CHK("duty16", 128, cnt)
		rd(`CAWD_A_CTRL);
		`CHK("flags", 8'h82, rv & 8'h82)
		// external ticks, idle suspend and clock enable
		wr(`CAWD_A_MODE, 8'h84);
		rd(`CAWD_A_CNTL);
		el = rv;
		@(posedge clk_sys) ext_tick <= 1'b1;
		repeat (5) @(posedge clk_sys);
		cpu_idle <= 1'b1;
		repeat (3) @(posedge clk_sys);
		cpu_idle <= 1'b0;
		ce       <= 1'b0;
		repeat (3) @(posedge clk_sys);
		ext_tick <= 1'b0;
		ce       <= 1'b1;
		rd(`CAWD_A_CNTL);
		`CHK("ext ticks", 8'(el + 5), rv)
		wrap_up();
	end
endmodule : counter_array_pwm_watchdog_tb_top
